// ---- core/acl_table3_key_builder.v ----
`include "acl3_consts.vh"

module acl_table3_key_builder (
    input  wire         clk_sys,                 // Core clock, 250 MHz.
    input  wire         rst_n,                   // Synchronous reset, active low.
    input  wire [7:0]   reg_addr,                // Register word index.
    input  wire [31:0]  reg_wdata,               // Register write data.
    input  wire         reg_wr,                  // Write strobe.
    input  wire         reg_rd,                  // Read strobe.
    output reg  [31:0]  reg_rdata,               // Read data, cycle after strobe.
    input  wire         pkt_valid,               // Parsed header present this cycle.
    input  wire [2:0]   port_prelookup_class_bits, // Bits from source-port table.
    input  wire [3:0]   port_rule_ptr,           // Fallback rule pointer.
    input  wire [5:0]   source_port,             // Ingress port number.
    input  wire [1:0]   vlan_count,              // Number of incoming tags.
    input  wire         audio_video_transport_class, // L2 class, 1 for transport.
    input  wire [1:0]   l3_class,                // L3 class code.
    input  wire [2:0]   l4_class,                // L4 class code from parser.
    input  wire [47:0]  mac_da,                  // Destination MAC.
    input  wire [47:0]  mac_sa,                  // Source MAC.
    input  wire [11:0]  outer_vlan_identifier,   // Outer tag id.
    input  wire         outer_tag_service,       // Outer tag is a service tag.
    input  wire         inner_tag_service,       // Inner tag is a service tag.
    input  wire [2:0]   outer_vlan_priority_code, // Outer priority.
    input  wire         outer_drop_eligible_flag, // Outer drop eligible.
    input  wire [11:0]  inner_vlan_identifier,   // Inner tag id.
    input  wire [2:0]   inner_vlan_priority_code, // Inner priority.
    input  wire         inner_drop_eligible_flag, // Inner drop eligible.
    input  wire [31:0]  ipv4_sa,                 // IPv4 source.
    input  wire [31:0]  ipv4_da,                 // IPv4 destination.
    input  wire [127:0] ipv6_sa,                 // IPv6 source.
    input  wire [127:0] ipv6_da,                 // IPv6 destination.
    input  wire [19:0]  mpls_label,              // Outermost MPLS label.
    input  wire [7:0]   ip_service_type_byte,    // IP service type byte.
    input  wire [7:0]   time_to_live,            // IPv4, IPv6 or MPLS TTL.
    input  wire [15:0]  l4_src_port,             // Transport source port.
    input  wire [15:0]  l4_dst_port,             // Transport destination port.
    input  wire [127:0] listener_address,        // Listener multicast address.
    input  wire [7:0]   icmp_type,               // ICMP or ICMPv6 type.
    input  wire [7:0]   icmp_code,               // ICMP code.
    input  wire [7:0]   igmp_type,               // IGMP type.
    input  wire [31:0]  igmp_group,              // IGMP group address.
    input  wire [7:0]   ip_protocol,             // IP protocol byte.
    input  wire [15:0]  ether_type,              // EtherType after tags.
    output reg          key_valid,               // One-cycle pulse with key.
    output reg  [221:0] search_key,              // Assembled search key.
    output reg  [3:0]   key_rule_ptr,            // Rule pointer used.
    output reg          key_overflow             // Rule broke field or width limit.
);

    reg  [30:0]  key_field_choice_mask [0:`RULE_COUNT-1];
    reg  [31:0]  pre_entry [0:`PRE_ENTRY_COUNT-1];
    reg  [15:0]  key_count;
    reg          last_overflow;

    // Widths follow the field-choice mask bit order.
    // Index 31 selects nothing and so has width zero.
    function [7:0] field_width;
        input [4:0] idx;
        begin
            case (idx)
                5'd0:  field_width = `FW_MAC_DA;
                5'd1:  field_width = `FW_MAC_SA;
                5'd2:  field_width = `FW_OUTER_VID;
                5'd3:  field_width = `FW_HAS_VLAN;
                5'd4:  field_width = `FW_TAG_TYPE;
                5'd5:  field_width = `FW_TAG_TYPE;
                5'd6:  field_width = `FW_PCP;
                5'd7:  field_width = `FW_DEI;
                5'd8:  field_width = `FW_INNER_VID;
                5'd9:  field_width = `FW_PCP;
                5'd10: field_width = `FW_DEI;
                5'd11: field_width = `FW_IPV4;
                5'd12: field_width = `FW_IPV4;
                5'd13: field_width = `FW_IPV6;
                5'd14: field_width = `FW_IPV6;
                5'd15: field_width = `FW_MPLS;
                5'd16: field_width = `FW_BYTE;
                5'd17: field_width = `FW_BYTE;
                5'd18: field_width = `FW_L4_PORT;
                5'd19: field_width = `FW_L4_PORT;
                5'd20: field_width = `FW_IPV6;
                5'd21: field_width = `FW_BYTE;
                5'd22: field_width = `FW_BYTE;
                5'd23: field_width = `FW_BYTE;
                5'd24: field_width = `FW_IGMP_GROUP;
                5'd25: field_width = `FW_BYTE;
                5'd26: field_width = `FW_ETHER_TYPE;
                5'd27: field_width = `FW_L4_CLASS;
                5'd28: field_width = `FW_L3_CLASS;
                5'd29: field_width = `FW_SRC_PORT;
                5'd30: field_width = `FW_RULE_PTR;
                default: field_width = 8'd0;
            endcase
        end
    endfunction

    // Pre-lookup: the lowest valid entry whose cared bits match wins.
    wire [10:0] pre_key = {port_prelookup_class_bits, vlan_count,
                           audio_video_transport_class, l3_class, l4_class};
    reg  [3:0]  rule_ptr;
    reg         pre_hit;
    integer     e;

    // The loop runs from the top entry down, so the last assignment,
    // the lowest matching entry, decides the pointer.
    // A cleared valid bit keeps an entry out of the search.
    always @* begin
        rule_ptr = port_rule_ptr;
        pre_hit  = 1'b0;
        for (e = `PRE_ENTRY_COUNT - 1; e >= 0; e = e - 1) begin
            if (pre_entry[e][`PRE_VALID_BIT] &&
                (((pre_key ^ pre_entry[e][`PRE_CARE_LSB-1:`PRE_VALUE_LSB]) &
                  pre_entry[e][`PRE_CARE_LSB+10:`PRE_CARE_LSB]) == 11'h000)) begin
                rule_ptr = pre_entry[e][`PRE_PTR_LSB+3:`PRE_PTR_LSB];
                pre_hit  = 1'b1;
            end
        end
    end

    // Validity terms shared by several fields of the key.
    // A single tag counts as the outer one; the inner tag needs two.
    wire is_ipv4  = (l3_class == `L3_IPV4);
    wire is_ipv6  = (l3_class == `L3_IPV6);
    wire is_ip    = is_ipv4 || is_ipv6;
    wire has_port = is_ip && (l4_class == `L4_UDP || l4_class == `L4_TCP);
    wire has_one  = (vlan_count != 2'h0);
    wire has_two  = (vlan_count[1] == 1'b1);
    wire listener = is_ipv6 && (icmp_type >= `LISTENER_TYPE_LO) &&
                    (icmp_type <= `LISTENER_TYPE_HI);
    // The parser only tells ICMPv6 apart; the key class splits on the message type.
    wire [2:0] key_l4_class = (l4_class == `L4_ICMPV6 || l4_class == `L4_LISTENER) ?
                              (listener ? `L4_LISTENER : `L4_ICMPV6) : l4_class;

    // Fallback and pre-lookup pointers reach the same rule storage.
    wire [30:0] choice = key_field_choice_mask[rule_ptr];

    // The key is built in a wider scratch word, so a rule that asks for
    // more than the key holds is flagged instead of wrapping around.
    // The position has room for six of the widest fields.
    reg  [255:0] next_key;
    reg          next_overflow;
    reg  [127:0] fval;
    reg          fok;
    reg  [9:0]   pos;
    reg  [2:0]   taken;
    reg  [4:0]   nsel;
    reg  [255:0] wmask;
    integer      i;

    always @* begin
        next_key      = 256'h0;
        next_overflow = 1'b0;
        fval          = 128'h0;
        fok           = 1'b0;
        wmask         = 256'h0;
        nsel          = 5'd0;
        taken         = 3'd0;
        // The count comes first, since it fixes where the first field starts.
        for (i = 0; i < `MASK_BITS; i = i + 1) begin
            nsel = nsel + {4'h0, choice[i]};
        end
        if (nsel > `MAX_FIELDS) begin
            next_overflow = 1'b1;
        end
        // Valid bits sit at the bottom, so the first field starts above them.
        pos = (nsel > `MAX_FIELDS) ? 10'd6 : {5'h00, nsel};
        for (i = 0; i < `MASK_BITS; i = i + 1) begin
            case (i)
                0:  fval = {80'h0, mac_da};
                1:  fval = {80'h0, mac_sa};
                2:  fval = {116'h0, outer_vlan_identifier};
                3:  fval = {127'h0, has_one};
                4:  fval = {127'h0, outer_tag_service};
                5:  fval = {127'h0, inner_tag_service};
                6:  fval = {125'h0, outer_vlan_priority_code};
                7:  fval = {127'h0, outer_drop_eligible_flag};
                8:  fval = {116'h0, inner_vlan_identifier};
                9:  fval = {125'h0, inner_vlan_priority_code};
                10: fval = {127'h0, inner_drop_eligible_flag};
                11: fval = {96'h0, ipv4_sa};
                12: fval = {96'h0, ipv4_da};
                13: fval = ipv6_sa;
                14: fval = ipv6_da;
                15: fval = {108'h0, mpls_label};
                16: fval = {120'h0, ip_service_type_byte};
                17: fval = {120'h0, time_to_live};
                18: fval = {112'h0, l4_src_port};
                19: fval = {112'h0, l4_dst_port};
                20: fval = listener_address;
                21: fval = {120'h0, icmp_type};
                22: fval = {120'h0, icmp_code};
                23: fval = {120'h0, igmp_type};
                24: fval = {96'h0, igmp_group};
                25: fval = {120'h0, ip_protocol};
                26: fval = {112'h0, ether_type};
                27: fval = {125'h0, key_l4_class};
                28: fval = {126'h0, l3_class};
                29: fval = {122'h0, source_port};
                default: fval = {124'h0, rule_ptr};
            endcase
            // Validity is decoded apart from the value, so each case reads as a table.
            // An invalid field still carries its input; only its valid bit is low.
            case (i)
                0:  fok = 1'b1;
                1:  fok = 1'b1;
                2:  fok = has_one;
                3:  fok = 1'b1;
                4:  fok = has_one;
                5:  fok = has_two;
                6:  fok = has_one;
                7:  fok = has_one;
                8:  fok = has_two;
                9:  fok = has_two;
                10: fok = has_two;
                11: fok = is_ipv4;
                12: fok = is_ipv4;
                13: fok = is_ipv6;
                14: fok = is_ipv6;
                15: fok = (l3_class == `L3_MPLS);
                16: fok = is_ip;
                17: fok = (l3_class != `L3_OTHER);
                18: fok = has_port;
                19: fok = has_port;
                20: fok = listener;
                21: fok = (l4_class == `L4_ICMP);
                22: fok = (l4_class == `L4_ICMP);
                23: fok = (l4_class == `L4_IGMP);
                24: fok = (l4_class == `L4_IGMP);
                25: fok = is_ip;
                26: fok = 1'b1;
                27: fok = 1'b1;
                28: fok = 1'b1;
                29: fok = 1'b1;
                default: fok = 1'b1;
            endcase
            // Fields beyond the sixth are dropped rather than shifting the key.
            if (choice[i] && (taken < `MAX_FIELDS)) begin
                wmask = ~({256{1'b1}} << field_width(i[4:0]));
                next_key = next_key | (({128'h0, fval} & wmask) << pos);
                next_key[taken] = fok;
                pos = pos + {2'b00, field_width(i[4:0])};
                taken = taken + 3'd1;
            end
        end
        // Bits above the key are cut; the flag tells software the rule
        // is too wide for this engine.
        if (pos > `KEY_WIDTH) begin
            next_overflow = 1'b1;
        end
        next_key[255:`KEY_WIDTH] = 34'h0;
    end

    integer r;

    // Key, pointer and flag move only on a header, so the key holds for the search
    // that follows while the parser idles.
    // The key counter wraps; software reads it as a running total.

    always @(posedge clk_sys) begin
        if (!rst_n) begin
            key_valid     <= 1'b0;
            search_key    <= 222'h0;
            key_rule_ptr  <= 4'h0;
            key_overflow  <= 1'b0;
            key_count     <= 16'h0;
            last_overflow <= 1'b0;
        end else begin
            key_valid <= pkt_valid;
            if (pkt_valid) begin
                search_key    <= next_key[221:0];
                key_rule_ptr  <= rule_ptr;
                key_overflow  <= next_overflow;
                last_overflow <= next_overflow;
                key_count     <= key_count + 16'h0001;
            end
        end
    end

    // Tables reset to zero: no pre-lookup hits and empty keys until configured.
    // Writes to the status word or unmapped indices are dropped.
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            for (r = 0; r < `RULE_COUNT; r = r + 1) begin
                key_field_choice_mask[r] <= 31'h0;
            end
            for (r = 0; r < `PRE_ENTRY_COUNT; r = r + 1) begin
                pre_entry[r] <= 32'h0;
            end
        end else if (reg_wr) begin
            if (reg_addr[7:4] == `REG_RULE_MASK_BASE >> 4) begin
                key_field_choice_mask[reg_addr[3:0]] <= reg_wdata[30:0];
            end else if (reg_addr[7:3] == `REG_PRE_ENTRY_BASE >> 3) begin
                pre_entry[reg_addr[2:0]] <= reg_wdata;
            end
        end
    end

    always @(posedge clk_sys) begin
        if (!rst_n) begin
            reg_rdata <= 32'h0;
        end else if (reg_rd) begin
            if (reg_addr[7:4] == `REG_RULE_MASK_BASE >> 4) begin
                reg_rdata <= {1'b0, key_field_choice_mask[reg_addr[3:0]]};
            end else if (reg_addr[7:3] == `REG_PRE_ENTRY_BASE >> 3) begin
                reg_rdata <= pre_entry[reg_addr[2:0]];
            end else if (reg_addr == `REG_STATUS) begin
                // Pointer and hit show the inputs of the read cycle,
                // not those of the last key built.
                reg_rdata <= {10'h0, pre_hit, rule_ptr, last_overflow, 16'h0}
                             | {16'h0, key_count};
            end else begin
                reg_rdata <= 32'h0;
            end
        end else begin
            reg_rdata <= 32'h0;
        end
    end

endmodule // acl_table3_key_builder

// ---- shared/acl3_consts.vh ----
`ifndef ACL3_CONSTS_VH
`define ACL3_CONSTS_VH

// Register word indices on the plain register port.
`define REG_RULE_MASK_BASE   8'h00
`define REG_PRE_ENTRY_BASE   8'h10
`define REG_STATUS           8'h20
`define RULE_COUNT           16
`define PRE_ENTRY_COUNT      8

// Pre-lookup entry word layout.
`define PRE_VALUE_LSB        0
`define PRE_CARE_LSB         11
`define PRE_PTR_LSB          24
`define PRE_VALID_BIT        31

// Key geometry.
`define KEY_WIDTH            222
`define MAX_FIELDS           6
`define MASK_BITS            31

// Field widths, by position in the field-choice mask.
`define FW_MAC_DA            8'd48
`define FW_MAC_SA            8'd48
`define FW_OUTER_VID         8'd12
`define FW_HAS_VLAN          8'd1
`define FW_TAG_TYPE          8'd1
`define FW_PCP               8'd3
`define FW_DEI               8'd1
`define FW_INNER_VID         8'd12
`define FW_IPV4              8'd32
`define FW_IPV6              8'd128
`define FW_MPLS              8'd20
`define FW_BYTE              8'd8
`define FW_L4_PORT           8'd16
`define FW_IGMP_GROUP        8'd32
`define FW_ETHER_TYPE        8'd16
`define FW_L4_CLASS          8'd3
`define FW_L3_CLASS          8'd2
`define FW_SRC_PORT          8'd6
`define FW_RULE_PTR          8'd4

// Class encodings.
`define L3_IPV4              2'h0
`define L3_IPV6              2'h1
`define L3_MPLS              2'h2
`define L3_OTHER             2'h3
`define L4_UNKNOWN           3'h0
`define L4_IP_OTHER          3'h1
`define L4_UDP               3'h2
`define L4_TCP               3'h3
`define L4_IGMP              3'h4
`define L4_ICMP              3'h5
`define L4_ICMPV6            3'h6
`define L4_LISTENER          3'h7
`define LISTENER_TYPE_LO     8'h82
`define LISTENER_TYPE_HI     8'h84

`endif

// ---- tb/acl_table3_key_builder_asserts.sv ----
module key_builder_checker (
    input wire logic         clk_sys,      // Clock.
    input wire logic         rst_n,        // Reset, active low.
    input wire logic [7:0]   reg_addr,     // Register index.
    input wire logic         reg_rd,       // Read strobe.
    input wire logic [31:0]  reg_rdata,    // Read data.
    input wire logic         pkt_valid,    // Header present.
    input wire logic         key_valid,    // Key pulse.
    input wire logic [221:0] search_key,   // Key.
    input wire logic [3:0]   key_rule_ptr, // Rule used.
    input wire logic         key_overflow  // Limit broken.
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);
    sequence s_pkt_in;
        pkt_valid;
    endsequence
    sequence s_key_out;
        key_valid;
    endsequence
    sequence s_mask_rd;
        reg_rd && (reg_addr < 8'h10);
    endsequence
    // The gap between the entry table and status must read as zero too.
    sequence s_bad_rd;
        reg_rd && ((reg_addr > 8'h20) || ((reg_addr >= 8'h18) && (reg_addr < 8'h20)));
    endsequence
    a_key_follows_pkt: assert property (s_pkt_in |=> s_key_out)
        else $error("key pulse missing after header");
    a_key_has_cause: assert property (s_key_out |-> $past(pkt_valid))
        else $error("key pulse without header");
    a_key_holds: assert property (!pkt_valid |=> $stable(search_key))
        else $error("key changed without header");
    a_ptr_holds: assert property ($changed(key_rule_ptr) |-> $past(pkt_valid))
        else $error("rule pointer changed without header");
    a_flag_holds: assert property ($changed(key_overflow) |-> $past(pkt_valid))
        else $error("overflow changed without header");
    a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 32'h0)
        else $error("read data outside read cycle");
    a_mask_top_zero: assert property (s_mask_rd |=> !reg_rdata[31])
        else $error("mask bit 31 not zero");
    a_unmapped_zero: assert property (s_bad_rd |=> reg_rdata == 32'h0)
        else $error("unmapped read not zero");
endmodule // key_builder_checker

bind acl_table3_key_builder key_builder_checker u_chk (.clk_sys(clk_sys), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pkt_valid(pkt_valid),
    .key_valid(key_valid), .search_key(search_key), .key_rule_ptr(key_rule_ptr),
    .key_overflow(key_overflow));

// ---- tb/acl_table3_key_builder_bench.sv ----
module acl_table3_key_builder_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic         clk_sys = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, pkt_valid = 1'b0;
    logic         audio_video_transport_class = 1'b0;
    logic [7:0]   reg_addr = 8'h00, seed = 8'h00, icmp_type = 8'h00;
    logic [31:0]  reg_wdata = 32'h0;
    logic [2:0]   port_prelookup_class_bits = 3'h0, l4_class = 3'h0;
    logic [3:0]   port_rule_ptr = 4'h0;
    logic [5:0]   source_port = 6'h2a;
    logic [1:0]   vlan_count = 2'h0, l3_class = 2'h0;
    wire  [47:0]  mac_da, mac_sa;
    wire  [11:0]  outer_vlan_identifier, inner_vlan_identifier;
    wire          outer_tag_service, inner_tag_service, key_valid, key_overflow;
    wire          outer_drop_eligible_flag, inner_drop_eligible_flag;
    wire  [2:0]   outer_vlan_priority_code, inner_vlan_priority_code;
    wire  [31:0]  ipv4_sa, ipv4_da, igmp_group, reg_rdata;
    wire  [127:0] ipv6_sa, ipv6_da, listener_address;
    wire  [19:0]  mpls_label;
    wire  [7:0]   ip_service_type_byte, time_to_live, icmp_code, igmp_type, ip_protocol;
    wire  [15:0]  l4_src_port, l4_dst_port, ether_type;
    wire  [221:0] search_key;
    wire  [3:0]   key_rule_ptr;
    int           failures = 0, checks = 0, cyc = 0;
    logic [226:0] exp_q[$];
    header_parser_model hdr (.seed, .mac_da, .mac_sa, .outer_vlan_identifier, .outer_tag_service,
        .inner_tag_service, .outer_vlan_priority_code, .outer_drop_eligible_flag,
        .inner_vlan_identifier, .inner_vlan_priority_code, .inner_drop_eligible_flag, .ipv4_sa,
        .ipv4_da, .ipv6_sa, .ipv6_da, .mpls_label, .ip_service_type_byte, .time_to_live,
        .l4_src_port, .l4_dst_port, .listener_address, .icmp_code, .igmp_type, .igmp_group,
        .ip_protocol, .ether_type);
    acl_table3_key_builder uut (.clk_sys, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .pkt_valid, .port_prelookup_class_bits, .port_rule_ptr, .source_port,
        .vlan_count, .audio_video_transport_class, .l3_class, .l4_class, .mac_da, .mac_sa,
        .outer_vlan_identifier, .outer_tag_service, .inner_tag_service,
        .outer_vlan_priority_code, .outer_drop_eligible_flag, .inner_vlan_identifier,
        .inner_vlan_priority_code, .inner_drop_eligible_flag, .ipv4_sa, .ipv4_da, .ipv6_sa,
        .ipv6_da, .mpls_label, .ip_service_type_byte, .time_to_live, .l4_src_port,
        .l4_dst_port, .listener_address, .icmp_type, .icmp_code, .igmp_type, .igmp_group,
        .ip_protocol, .ether_type, .key_valid, .search_key, .key_rule_ptr, .key_overflow);
    always #2 clk_sys = ~clk_sys;
    task automatic finish_test;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            failures++;
            finish_test;
        end
    end
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %0t word %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_key(input logic [226:0] got, input logic [226:0] exp);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %0t key %h expected %h", $time, got, exp);
        end
    endtask
    // A key with nothing queued is compared against unknown, so it always fails.
    always @(negedge clk_sys) begin
        if (key_valid === 1'b1)
            chk_key({key_overflow, key_rule_ptr, search_key}, exp_q.size() ? exp_q.pop_front() : 'x);
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 chk_word(reg_rdata, e);
    endtask
    // The class argument is laid out exactly as the pre-lookup key.
    task automatic send(input logic [7:0] s, input logic [10:0] pre, input logic [7:0] ic,
                        input logic [226:0] e);
        @(posedge clk_sys);
        seed <= s;
        icmp_type <= ic;
        {port_prelookup_class_bits, vlan_count, audio_video_transport_class, l3_class,
         l4_class} <= pre;
        pkt_valid <= 1'b1;
        exp_q.push_back(e);
    endtask
    task automatic idle;
        @(posedge clk_sys);
        pkt_valid <= 1'b0;
        @(posedge clk_sys);
        #1 chk_word(exp_q.size(), 32'h0);
    endtask
    task automatic t_regs;
        chk_key({key_overflow, key_rule_ptr, search_key}, 227'h0);
        wr(8'h00, 32'hffffffff);
        rdc(8'h00, 32'h7fffffff);
        wr(8'h17, 32'h7edcba98);
        rdc(8'h17, 32'h7edcba98);
        wr(8'h20, 32'hffffffff);
        rdc(8'h20, 32'h0);
        rdc(8'h18, 32'h0);
        wr(8'h00, 32'h0);
    endtask
    task automatic t_fallback;
        wr(8'h05, 32'h70000000);
        port_rule_ptr <= 4'h5;
        send(8'h33, 11'h018, 8'h00, {1'b0, 4'h5, 207'h0, 4'h5, 6'h2a, 2'h3, 3'h7});
        idle;
    endtask
    // Three headers back to back: two hit the pre-lookup, the IPv4 one falls back.
    task automatic t_prelookup;
        wr(8'h10, 32'h893ffdae);
        wr(8'h09, 32'h48002000);
        send(8'h5c, 11'h5ae, 8'h83, {5'h09, 84'h0, 4'h9, 3'h7, {16{8'h5c}}, 3'h7});
        send(8'ha1, 11'h5ae, 8'h80, {5'h09, 84'h0, 4'h9, 3'h6, {16{8'ha1}}, 3'h7});
        send(8'h07, 11'h5a6, 8'h80, {5'h05, 207'h0, 4'h5, 6'h2a, 2'h0, 3'h7});
        idle;
    endtask
    task automatic t_overflow;
        wr(8'h05, 32'h0000007f);
        send(8'h96, 11'h058, 8'h00, {5'h15, 105'h0, 3'h5, 12'h696, {6{8'h69}}, {6{8'h96}},
             6'h1f});
        idle;
        wr(8'h05, 32'h00006000);
        send(8'h3c, 11'h018, 8'h00, {5'h15, 4'h3, {11{8'hc3}}, {16{8'h3c}}, 2'h0});
        idle;
        rdc(8'h20, 32'h000b0006);
    endtask
    initial begin
        repeat (10) @(posedge clk_sys);
        rst_n <= 1'b1;
        t_regs;
        t_fallback;
        t_prelookup;
        t_overflow;
        finish_test;
    end
endmodule // acl_table3_key_builder_bench

// ---- tb/header_parser_model.sv ----
module header_parser_model (
    input  wire logic [7:0]   seed,                     // Packet pattern.
    output wire logic [47:0]  mac_da,                   // Field.
    output wire logic [47:0]  mac_sa,                   // Field.
    output wire logic [11:0]  outer_vlan_identifier,    // Field.
    output wire logic         outer_tag_service,        // Field.
    output wire logic         inner_tag_service,        // Field.
    output wire logic [2:0]   outer_vlan_priority_code, // Field.
    output wire logic         outer_drop_eligible_flag, // Field.
    output wire logic [11:0]  inner_vlan_identifier,    // Field.
    output wire logic [2:0]   inner_vlan_priority_code, // Field.
    output wire logic         inner_drop_eligible_flag, // Field.
    output wire logic [31:0]  ipv4_sa,                  // Field.
    output wire logic [31:0]  ipv4_da,                  // Field.
    output wire logic [127:0] ipv6_sa,                  // Field.
    output wire logic [127:0] ipv6_da,                  // Field.
    output wire logic [19:0]  mpls_label,               // Field.
    output wire logic [7:0]   ip_service_type_byte,     // Field.
    output wire logic [7:0]   time_to_live,             // Field.
    output wire logic [15:0]  l4_src_port,              // Field.
    output wire logic [15:0]  l4_dst_port,              // Field.
    output wire logic [127:0] listener_address,         // Field.
    output wire logic [7:0]   icmp_code,                // Field.
    output wire logic [7:0]   igmp_type,                // Field.
    output wire logic [31:0]  igmp_group,               // Field.
    output wire logic [7:0]   ip_protocol,              // Field.
    output wire logic [15:0]  ether_type                // Field.
);
    timeunit 1ns;
    timeprecision 1ps;
    // Every field differs per seed so a field placed at the wrong offset shows up.
    assign {mac_da, mac_sa, outer_vlan_identifier, outer_tag_service, inner_tag_service,
            outer_vlan_priority_code, outer_drop_eligible_flag, inner_vlan_identifier,
            inner_vlan_priority_code, inner_drop_eligible_flag, ipv4_sa, ipv4_da,
            ipv6_sa, ipv6_da, mpls_label, ip_service_type_byte, time_to_live} =
           {{6{seed}}, {6{~seed}}, seed[3:0], seed, seed[0], seed[1], seed[2:0], seed[3],
            seed, seed[7:4], seed[5:3], seed[4], {4{seed}}, {4{~seed}}, {16{seed}},
            {16{~seed}}, seed, seed, seed[3:0], seed, ~seed};
    assign {l4_src_port, l4_dst_port, listener_address, icmp_code, igmp_type, igmp_group,
            ip_protocol, ether_type} =
           {seed, ~seed, ~seed, seed, {16{seed ^ 8'h3c}}, ~seed, seed ^ 8'h22,
            {4{seed ^ 8'h0f}}, seed ^ 8'h11, seed, 8'h00};
endmodule // header_parser_model
